// >>> rtl/adrr_core.sv
// Read acceleration command decoder and response builder with register slave
//
// Decided for this implementation: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps

module adrr_core
   import adrr_pkg::*;
(
   // Clock and reset
   input  wire logic                  clk,
   input  wire logic                  resetn,
   // Avalon-MM slave
   input  wire logic [4:0]            avs_address,
   input  wire logic                  avs_read,
   input  wire logic                  avs_write,
   input  wire logic [31:0]           avs_writedata,
   input  wire logic [3:0]            avs_byteenable,
   output logic      [31:0]           avs_readdata,
   output logic                       avs_waitrequest,
   output logic                       irq,
   // Decoded command frame
   input  wire logic                  cmd_valid,
   input  wire logic [15:0]           cmd_word,
   input  wire adrr_fmt_t             cmd_format,
   input  wire logic [ADRR_LEN_W-1:0] cmd_resp_len,
   input  wire logic                  cmd_crc_ok,
   input  wire logic                  clear_cmd,
   // Sensor state
   input  wire logic [ADRR_RES_W-1:0] accel_result,
   input  wire logic                  sensor_error,
   input  wire logic                  internal_error,
   input  wire logic                  self_test_active,
   // Response to transmitter
   output logic                       resp_valid,
   output logic [15:0]                resp_data,
   output logic [ADRR_LEN_W-1:0]      resp_len,
   input  wire logic                  resp_done
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [2:0]            ctrl_reg;
   logic [3:0]            devaddr_reg;
   logic [1:0]            attribute_bits;
   logic [ADRR_EV_W-1:0]  status_reg;
   logic [ADRR_EV_W-1:0]  mask_reg;
   logic                  ack_reg;
   logic [31:0]           rdata_reg;
   adrr_state_t           state_reg;
   logic [15:0]           resp_data_reg;
   logic [ADRR_LEN_W-1:0] resp_len_reg;
   logic                  bus_req;
   logic                  wr_fire;
   logic                  is_long;
   logic                  fmt_ok;
   logic                  len_ok;
   logic                  hit;
   logic                  accept;
   logic [3:0]            cmd_code;
   logic [3:0]            cmd_addr;
   logic [ADRR_RES_W-1:0] code;
   logic [15:0]           short_word;
   logic [15:0]           short_mask;
   logic                  zero_fix;
   logic [ADRR_EV_W-1:0]  ev_set;
   logic [ADRR_EV_W-1:0]  ev_clr;

   // ----------------------------------------------------------------
   // Avalon slave handshake
   // ----------------------------------------------------------------
   assign bus_req         = avs_read | avs_write;
   assign avs_waitrequest = bus_req & ~ack_reg;
   assign wr_fire         = avs_write & ack_reg & avs_byteenable[0];
   assign avs_readdata    = rdata_reg;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= bus_req & ~ack_reg;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rdata_reg <= 32'h0;
      end else if (avs_read & ~ack_reg) begin
         rdata_reg <= 32'h0;
         case (avs_address)
            ADRR_OFS_CTRL:    rdata_reg[2:0] <= ctrl_reg;
            ADRR_OFS_DEVADDR: rdata_reg[3:0] <= devaddr_reg;
            ADRR_OFS_CFG1:    rdata_reg[1:0] <= attribute_bits;
            ADRR_OFS_STATUS:  rdata_reg[ADRR_EV_W-1:0] <= status_reg;
            ADRR_OFS_MASK:    rdata_reg[ADRR_EV_W-1:0] <= mask_reg;
            ADRR_OFS_RESP: begin
               rdata_reg[15:0] <= resp_data_reg;
               rdata_reg[ADRR_RESP_LEN_LSB +: ADRR_LEN_W] <= resp_len_reg;
               rdata_reg[ADRR_RESP_BUSY] <= (state_reg == ADRR_ST_HOLD);
            end
            default:          rdata_reg <= 32'h0;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_reg <= ADRR_CTRL_RESET;
      end else if (wr_fire && avs_address == ADRR_OFS_CTRL) begin
         ctrl_reg <= avs_writedata[2:0];
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         devaddr_reg <= ADRR_DEVADDR_RESET;
      end else if (wr_fire && avs_address == ADRR_OFS_DEVADDR) begin
         devaddr_reg <= avs_writedata[3:0];
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         attribute_bits <= ADRR_CFG1_RESET;
      end else if (wr_fire && avs_address == ADRR_OFS_CFG1) begin
         attribute_bits <= avs_writedata[1:0];
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         mask_reg <= '0;
      end else if (wr_fire && avs_address == ADRR_OFS_MASK) begin
         mask_reg <= avs_writedata[ADRR_EV_W-1:0];
      end
   end

   // ----------------------------------------------------------------
   // Command decode
   // ----------------------------------------------------------------
   // Data byte of the command word is deliberately not looked at
   assign cmd_code = cmd_word[ADRR_CMD_LSB +: 4];
   assign cmd_addr = cmd_word[ADRR_ADDR_LSB +: 4];
   assign is_long  = (cmd_format == ADRR_FMT_STD_LONG) ||
                     (cmd_format == ADRR_FMT_ENH_LONG);

   always_comb begin
      case (cmd_format)
         ADRR_FMT_STD_LONG,
         ADRR_FMT_STD_SHORT: fmt_ok = 1'b1;
         ADRR_FMT_ENH_LONG:  fmt_ok = ctrl_reg[ADRR_CTRL_ENH_LONG];
         ADRR_FMT_ENH_SHORT: fmt_ok = ctrl_reg[ADRR_CTRL_ENH_SHORT];
         default:            fmt_ok = 1'b0;
      endcase
   end

   assign len_ok = is_long ||
                   (cmd_resp_len >= ADRR_LEN_MIN && cmd_resp_len <= ADRR_LEN_MAX);
   assign hit    = cmd_valid & cmd_crc_ok & ctrl_reg[ADRR_CTRL_EN] & ~clear_cmd &
                   (cmd_code == ADRR_CMD_READ_ACCEL);
   assign accept = hit & (devaddr_reg != ADRR_ADDR_GLOBAL)
                 & (cmd_addr == devaddr_reg)
                 & fmt_ok & len_ok & (state_reg == ADRR_ST_IDLE);

   // ----------------------------------------------------------------
   // Response formatting
   // ----------------------------------------------------------------
   always_comb begin
      code       = accel_result;
      zero_fix   = 1'b0;
      short_word = 16'h0;
      if (!is_long) begin
         if (cmd_resp_len == ADRR_LEN_MIN) begin
            code = {2'h0, accel_result[ADRR_RES_W-1:2]};
         end else if (cmd_resp_len == ADRR_LEN_NINE) begin
            code = {1'h0, accel_result[ADRR_RES_W-1:1]};
         end
      end
      if (sensor_error) begin
         code = ADRR_CODE_ERROR;
      end else if (code == ADRR_CODE_ERROR) begin
         code     = ADRR_CODE_MIN;
         zero_fix = 1'b1;
      end
      short_word[ADRR_RES_W-1:0] = code;
      if (cmd_resp_len > ADRR_LEN_NINE) begin
         short_word[ADRR_SH_ERR]  = internal_error;
         short_word[ADRR_SH_ZERO] = 1'b0;
         short_word[ADRR_SH_ST]   = self_test_active;
         short_word[ADRR_SH_AT0]  = attribute_bits[0];
         short_word[ADRR_SH_AT1]  = attribute_bits[1];
      end
   end

   assign short_mask = 16'((17'h1 << cmd_resp_len) - 17'h1);

   // ----------------------------------------------------------------
   // Response hold state
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= ADRR_ST_IDLE;
      end else begin
         case (state_reg)
            ADRR_ST_IDLE: begin
               if (accept) begin
                  state_reg <= ADRR_ST_HOLD;
               end
            end
            ADRR_ST_HOLD: begin
               if (resp_done || clear_cmd) begin
                  state_reg <= ADRR_ST_IDLE;
               end
            end
            default: state_reg <= ADRR_ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         resp_data_reg <= 16'h0;
         resp_len_reg  <= '0;
      end else if (accept) begin
         // Captured once, unchanged while held
         if (is_long) begin
            resp_data_reg <= {devaddr_reg, 1'b0, internal_error,
                              code};
            resp_len_reg  <= ADRR_LEN_LONG;
         end else begin
            resp_data_reg <= short_word & short_mask;
            resp_len_reg  <= cmd_resp_len;
         end
      end
   end

   assign resp_valid = (state_reg == ADRR_ST_HOLD);
   assign resp_data  = resp_data_reg;
   assign resp_len   = resp_len_reg;

   // ----------------------------------------------------------------
   // Event status and interrupt
   // ----------------------------------------------------------------
   always_comb begin
      ev_set                   = '0;
      ev_set[ADRR_EV_DONE]     = resp_valid & resp_done;
      ev_set[ADRR_EV_MISMATCH] = hit & (devaddr_reg != ADRR_ADDR_GLOBAL) &
                                 (cmd_addr != devaddr_reg);
      ev_set[ADRR_EV_UNPROG]   = hit & (devaddr_reg == ADRR_ADDR_GLOBAL);
      ev_set[ADRR_EV_ZEROFIX]  = accept & zero_fix;
      ev_set[ADRR_EV_SENSERR]  = accept & sensor_error;
      ev_set[ADRR_EV_REJECT]   = hit & (cmd_addr == devaddr_reg) &
                                 (devaddr_reg != ADRR_ADDR_GLOBAL) & ~accept;
   end

   assign ev_clr = (wr_fire && avs_address == ADRR_OFS_STATUS) ?
                   avs_writedata[ADRR_EV_W-1:0] : '0;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         status_reg <= '0;
      end else begin
         status_reg <= (status_reg & ~ev_clr) | ev_set;
      end
   end

   assign irq = |(status_reg & mask_reg);

endmodule : adrr_core

// >>> rtl/adrr_pkg.sv
// Constants and types for the acceleration read response builder
package adrr_pkg;
   // ----------------------------------------------------------------
   // Command word layout {data[7:0], address[3:0], command[3:0]}
   // ----------------------------------------------------------------
   localparam logic [3:0] ADRR_CMD_READ_ACCEL = 4'h2;
   localparam logic [3:0] ADRR_ADDR_GLOBAL    = 4'h0;
   localparam int         ADRR_CMD_LSB        = 0;
   localparam int         ADRR_ADDR_LSB       = 4;
   localparam int         ADRR_DATA_LSB       = 8;

   // ----------------------------------------------------------------
   // Response layout
   // ----------------------------------------------------------------
   localparam int         ADRR_RES_W          = 10;
   localparam int         ADRR_LEN_W          = 5;
   localparam logic [4:0] ADRR_LEN_MIN        = 5'h08;
   localparam logic [4:0] ADRR_LEN_NINE       = 5'h09;
   localparam logic [4:0] ADRR_LEN_MAX        = 5'h0f;
   localparam logic [4:0] ADRR_LEN_LONG       = 5'h10;
   localparam int         ADRR_SH_ERR         = 10;
   localparam int         ADRR_SH_ZERO        = 11;
   localparam int         ADRR_SH_ST          = 12;
   localparam int         ADRR_SH_AT0         = 13;
   localparam int         ADRR_SH_AT1         = 14;
   localparam int         ADRR_LG_ERR         = 10;
   localparam int         ADRR_LG_ZERO        = 11;
   localparam int         ADRR_LG_ADDR        = 12;
   localparam logic [9:0] ADRR_CODE_MIN       = 10'h001;
   localparam logic [9:0] ADRR_CODE_ERROR     = 10'h000;

   // ----------------------------------------------------------------
   // Register map, byte addresses
   // ----------------------------------------------------------------
   localparam logic [4:0] ADRR_OFS_CTRL       = 5'h00;
   localparam logic [4:0] ADRR_OFS_DEVADDR    = 5'h04;
   localparam logic [4:0] ADRR_OFS_CFG1       = 5'h08;
   localparam logic [4:0] ADRR_OFS_STATUS     = 5'h0c;
   localparam logic [4:0] ADRR_OFS_MASK       = 5'h10;
   localparam logic [4:0] ADRR_OFS_RESP       = 5'h14;
   localparam int         ADRR_CTRL_EN        = 0;
   localparam int         ADRR_CTRL_ENH_LONG  = 1;
   localparam int         ADRR_CTRL_ENH_SHORT = 2;
   localparam logic [2:0] ADRR_CTRL_RESET     = 3'h1;
   localparam logic [3:0] ADRR_DEVADDR_RESET  = 4'h0;
   localparam logic [1:0] ADRR_CFG1_RESET     = 2'h0;
   localparam int         ADRR_EV_W           = 6;
   localparam int         ADRR_EV_DONE        = 0;
   localparam int         ADRR_EV_MISMATCH    = 1;
   localparam int         ADRR_EV_UNPROG      = 2;
   localparam int         ADRR_EV_ZEROFIX     = 3;
   localparam int         ADRR_EV_SENSERR     = 4;
   localparam int         ADRR_EV_REJECT      = 5;
   localparam int         ADRR_RESP_LEN_LSB   = 16;
   localparam int         ADRR_RESP_BUSY      = 24;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      ADRR_FMT_STD_LONG,
      ADRR_FMT_STD_SHORT,
      ADRR_FMT_ENH_LONG,
      ADRR_FMT_ENH_SHORT
   } adrr_fmt_t;

   typedef enum logic {
      ADRR_ST_IDLE,
      ADRR_ST_HOLD
   } adrr_state_t;
endpackage : adrr_pkg

// >>> tb/adrr_chk.sv
// Assertion checker for the acceleration read response builder
`timescale 1ns/1ps
module adrr_chk
   import adrr_pkg::*;
(
   // Clock, reset and register bus
   input wire logic                  clk,
   input wire logic                  resetn,
   input wire logic                  avs_read,
   input wire logic                  avs_write,
   input wire logic                  avs_waitrequest,
   // Command, sensor and response
   input wire logic                  cmd_valid,
   input wire logic [15:0]           cmd_word,
   input wire logic                  clear_cmd,
   input wire logic [ADRR_RES_W-1:0] accel_result,
   input wire logic                  sensor_error,
   input wire logic                  internal_error,
   input wire logic                  resp_valid,
   input wire logic [15:0]           resp_data,
   input wire logic [ADRR_LEN_W-1:0] resp_len,
   input wire logic                  resp_done
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // ----------------------------------------
   // Inputs as seen at the acceptance edge
   // ----------------------------------------
   logic [3:0] a_q;
   logic [9:0] r_q;
   logic       e_q, s_q;
   always_ff @(posedge clk) begin
      a_q <= cmd_word[7:4];
      r_q <= accel_result;
      e_q <= internal_error;
      s_q <= sensor_error;
   end
   sequence s_ack; avs_waitrequest ##1 !avs_waitrequest; endsequence
   sequence s_new; $rose(resp_valid); endsequence
   AST_BUS_WAIT: assert property ($rose(avs_read || avs_write) |-> s_ack)
      else $error("bus answer not after one wait cycle");
   AST_BAD_CODE: assert property (cmd_valid && cmd_word[3:0] != ADRR_CMD_READ_ACCEL
      && !resp_valid |=> !resp_valid) else $error("answer to other command code");
   AST_GLOBAL: assert property (cmd_valid && cmd_word[7:4] == ADRR_ADDR_GLOBAL
      && !resp_valid |=> !resp_valid) else $error("answer to global address");
   AST_HOLD: assert property (resp_valid && !resp_done && !clear_cmd |=>
      resp_valid && $stable(resp_data) && $stable(resp_len)) else $error("response moved");
   AST_LONG: assert property (s_new ##0 resp_len == ADRR_LEN_LONG |->
      resp_data[15:10] == {a_q, 1'b0, e_q}) else $error("long header wrong");
   AST_RESULT: assert property (s_new ##0 resp_len == ADRR_LEN_LONG && r_q != 0 && !s_q
      |-> resp_data[9:0] == r_q) else $error("long result wrong");
   AST_TRUNC8: assert property (s_new ##0 resp_len == ADRR_LEN_MIN && r_q[9:2] != 0
      && !s_q |-> resp_data == {8'h00, r_q[9:2]}) else $error("length 8 result wrong");
   AST_ZEROFIX: assert property (s_new ##0 resp_len == ADRR_LEN_MIN && r_q[9:2] == 0
      && !s_q |-> resp_data == 16'h0001) else $error("zero not replaced by one");
   AST_SENSERR: assert property (s_new ##0 s_q && resp_len == ADRR_LEN_MIN
      |-> resp_data == 16'h0000) else $error("sensor error code wrong");
endmodule : adrr_chk

bind adrr_core adrr_chk u_chk (
   .clk(clk), .resetn(resetn), .avs_read(avs_read), .avs_write(avs_write),
   .avs_waitrequest(avs_waitrequest), .cmd_valid(cmd_valid), .cmd_word(cmd_word),
   .clear_cmd(clear_cmd), .accel_result(accel_result), .sensor_error(sensor_error),
   .internal_error(internal_error), .resp_valid(resp_valid), .resp_data(resp_data),
   .resp_len(resp_len), .resp_done(resp_done));

// >>> tb/adrr_master_model.sv
// Sensor bus master model: sends commands and completes responses
`timescale 1ns/1ps
module adrr_master_model
   import adrr_pkg::*;
(
   // Clock and response status
   input  wire logic   clk,
   input  wire logic   resp_valid,
   // Command frame and completion
   output logic        cmd_valid = 1'b0,
   output logic [15:0] cmd_word = 16'h0000,
   output adrr_fmt_t   cmd_format = ADRR_FMT_STD_LONG,
   output logic [4:0]  cmd_resp_len = 5'h08,
   output logic        cmd_crc_ok = 1'b0,
   output logic        resp_done = 1'b0
);
   // ----------------------------------------
   // Frame issue and response completion
   // ----------------------------------------
   int unsigned done_dly = 0;
   int unsigned cnt = 0;
   task automatic send(input logic [15:0] w, input adrr_fmt_t f, input logic [4:0] n);
      cmd_valid <= 1'b1;
      cmd_crc_ok <= 1'b1;
      cmd_word <= w;
      cmd_format <= f;
      cmd_resp_len <= n;
      @(posedge clk);
      cmd_valid <= 1'b0;
      cmd_crc_ok <= 1'b0;
      cmd_word <= ~w;
   endtask : send
   always @(posedge clk) begin
      resp_done <= resp_valid && !resp_done && (cnt >= done_dly);
      if (resp_valid && !resp_done) begin
         cnt <= (cnt >= done_dly) ? 0 : cnt + 1;
      end
   end
endmodule : adrr_master_model

// >>> tb/testbench.sv
// Self-checking testbench for the acceleration read response builder
`timescale 1ns/1ps
module testbench
   import adrr_pkg::*;
;
   logic        clk = 1'b0;
   logic        resetn = 1'b0;
   logic [4:0]  avs_address = 5'h00;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata, rd;
   logic        avs_waitrequest, irq, cmd_valid, cmd_crc_ok, resp_valid, resp_done;
   logic [15:0] cmd_word, resp_data;
   adrr_fmt_t   cmd_format;
   logic [4:0]  cmd_resp_len, resp_len;
   logic [9:0]  accel_result = 10'h200;
   logic        sensor_error = 1'b0;
   logic        internal_error = 1'b0;
   logic        self_test_active = 1'b0;
   logic        clear_cmd = 1'b0;
   logic [1:0]  attribute_bits = 2'h2;
   int          n_errors = 0;
   int          compares = 0;
   always #12.5 clk = ~clk;
   adrr_core u_dut (
      .clk(clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
      .cmd_valid(cmd_valid), .cmd_word(cmd_word), .cmd_format(cmd_format),
      .cmd_resp_len(cmd_resp_len), .cmd_crc_ok(cmd_crc_ok), .clear_cmd(clear_cmd),
      .accel_result(accel_result), .sensor_error(sensor_error),
      .internal_error(internal_error), .self_test_active(self_test_active),
      .resp_valid(resp_valid), .resp_data(resp_data), .resp_len(resp_len),
      .resp_done(resp_done));
   adrr_master_model u_mst (
      .clk(clk), .resp_valid(resp_valid), .cmd_valid(cmd_valid), .cmd_word(cmd_word),
      .cmd_format(cmd_format), .cmd_resp_len(cmd_resp_len), .cmd_crc_ok(cmd_crc_ok),
      .resp_done(resp_done));
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk);
   endtask : bus
   task automatic irq_is(input logic b);
      @(negedge clk);
      chk("irq", {31'h0, b}, {31'h0, irq});
      @(posedge clk);
   endtask : irq_is
   function automatic logic [15:0] exp_resp(input logic [4:0] n);
      logic [9:0] c;
      c = (n == 5'h08) ? {2'h0, accel_result[9:2]}
        : (n == 5'h09) ? {1'h0, accel_result[9:1]} : accel_result;
      if (sensor_error) c = 10'h000;
      else if (c == 10'h000) c = 10'h001;
      if (n == ADRR_LEN_LONG) return {4'h5, 1'b0, internal_error, c};
      return {1'b0, attribute_bits, self_test_active, 1'b0, internal_error, c}
             & ((16'h0001 << n) - 16'h0001);
   endfunction : exp_resp
   task automatic cmd(input logic [3:0] a, input logic [3:0] c, input adrr_fmt_t f,
                      input logic [4:0] n, input logic ok);
      logic [4:0]  el;
      logic [15:0] e;
      el = f[0] ? n : ADRR_LEN_LONG;
      e = exp_resp(el);
      u_mst.send({3'h0, n, a, c}, f, n);
      @(negedge clk);
      chk("resp_valid", {31'h0, ok}, {31'h0, resp_valid});
      if (ok) begin
         chk("resp_len", {27'h0, el}, {27'h0, resp_len});
         @(posedge clk);
         accel_result <= ~accel_result;
         while (resp_valid === 1'b1) begin
            chk("resp_data", {16'h0, e}, {16'h0, resp_data});
            @(negedge clk);
         end
      end
      @(posedge clk);
   endtask : cmd
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_regs();
      bus(1'b0, ADRR_OFS_CTRL, 32'h0);
      chk("ctrl", 32'h1, rd);
      bus(1'b1, 5'h18, 32'hff);
      bus(1'b0, 5'h18, 32'h0);
      chk("unmapped", 32'h0, rd);
   endtask : t_regs
   task automatic t_unprog();
      cmd(4'h0, ADRR_CMD_READ_ACCEL, ADRR_FMT_STD_LONG, 5'h10, 1'b0);
      bus(1'b0, ADRR_OFS_STATUS, 32'h0);
      chk("status", 32'h4, rd);
      bus(1'b1, ADRR_OFS_DEVADDR, 32'h5);
      bus(1'b1, ADRR_OFS_CFG1, {30'h0, attribute_bits});
   endtask : t_unprog
   task automatic t_long();
      u_mst.done_dly = 4;
      internal_error <= 1'b1;
      accel_result <= 10'h2a7;
      @(posedge clk);
      cmd(4'h5, ADRR_CMD_READ_ACCEL, ADRR_FMT_STD_LONG, 5'h10, 1'b1);
      u_mst.done_dly = 0;
   endtask : t_long
   task automatic t_short();
      self_test_active <= 1'b1;
      for (int n = 8; n < 16; n++) begin
         accel_result <= 10'h2c6;
         @(posedge clk);
         cmd(4'h5, ADRR_CMD_READ_ACCEL, ADRR_FMT_STD_SHORT, 5'(n), 1'b1);
      end
   endtask : t_short
   task automatic t_zero();
      logic [9:0] v[5] = '{10'h003, 10'h001, 10'h3ff, 10'h200, 10'h155};
      logic [4:0] l[5] = '{5'h08, 5'h09, 5'h08, 5'h09, 5'h08};
      for (int i = 0; i < 5; i++) begin
         accel_result <= v[i];
         sensor_error <= (i == 4);
         @(posedge clk);
         cmd(4'h5, ADRR_CMD_READ_ACCEL, ADRR_FMT_STD_SHORT, l[i], 1'b1);
      end
      sensor_error <= 1'b0;
   endtask : t_zero
   task automatic t_ignore();
      bus(1'b1, ADRR_OFS_STATUS, 32'h3f);
      cmd(4'h6, ADRR_CMD_READ_ACCEL, ADRR_FMT_STD_LONG, 5'h10, 1'b0);
      cmd(4'h5, 4'h1, ADRR_FMT_STD_LONG, 5'h10, 1'b0);
      bus(1'b0, ADRR_OFS_STATUS, 32'h0);
      chk("status", 32'h2, rd);
   endtask : t_ignore
   task automatic t_fmt();
      bus(1'b1, ADRR_OFS_STATUS, 32'h3f);
      cmd(4'h5, ADRR_CMD_READ_ACCEL, ADRR_FMT_ENH_LONG, 5'h0a, 1'b0);
      bus(1'b0, ADRR_OFS_STATUS, 32'h0);
      chk("status", 32'h20, rd);
      bus(1'b1, ADRR_OFS_CTRL, 32'h7);
      cmd(4'h5, ADRR_CMD_READ_ACCEL, ADRR_FMT_ENH_LONG, 5'h0a, 1'b1);
      cmd(4'h5, ADRR_CMD_READ_ACCEL, ADRR_FMT_ENH_SHORT, 5'h0c, 1'b1);
      cmd(4'h5, ADRR_CMD_READ_ACCEL, ADRR_FMT_STD_SHORT, 5'h07, 1'b0);
   endtask : t_fmt
   task automatic t_irq();
      bus(1'b1, ADRR_OFS_STATUS, 32'h3f);
      bus(1'b1, ADRR_OFS_MASK, 32'h1);
      irq_is(1'b0);
      cmd(4'h5, ADRR_CMD_READ_ACCEL, ADRR_FMT_STD_LONG, 5'h10, 1'b1);
      irq_is(1'b1);
      bus(1'b1, ADRR_OFS_MASK, 32'h0);
      irq_is(1'b0);
      bus(1'b1, ADRR_OFS_STATUS, 32'h1);
      bus(1'b1, ADRR_OFS_MASK, 32'h1);
      irq_is(1'b0);
   endtask : t_irq
   task automatic t_clear();
      logic [15:0] e;
      e = exp_resp(ADRR_LEN_LONG);
      u_mst.done_dly = 50;
      u_mst.send({8'h00, 4'h5, ADRR_CMD_READ_ACCEL}, ADRR_FMT_STD_LONG, 5'h10);
      bus(1'b0, ADRR_OFS_RESP, 32'h0);
      chk("resp_reg", {7'h0, 1'b1, 3'h0, ADRR_LEN_LONG, e}, rd);
      clear_cmd <= 1'b1;
      @(posedge clk);
      clear_cmd <= 1'b0;
      @(negedge clk);
      chk("resp_valid", 32'h0, {31'h0, resp_valid});
      u_mst.done_dly = 0;
      @(posedge clk);
   endtask : t_clear
   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : summarize
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      summarize();
   end
   initial begin
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      t_regs();
      t_unprog();
      t_long();
      t_short();
      t_zero();
      t_ignore();
      t_fmt();
      t_irq();
      t_clear();
      summarize();
   end
endmodule : testbench
